/* design/gpx_top.sv */
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps

// Operation
// - three open-drain pins, each configurable as input or output
// - output pin level follows the host-written value
// - pins one and two raise an interrupt on a pin transition
// - a mask bit suppresses each of pin one's and pin two's interrupt request
// - pin one drives converter one and standby; pin two converter two
// - pin two level switches converter two; host picks active level
// - pin three starts an a/d conversion, enabled in adc register
// - after reset every pin is input with no function
// - pin passes two latching stages before interrupt logic
// - first selected edge sets first stage and pulls interrupt low
// - read clears latch only with first stage low; opposite edge clears it
// - interrupt released by a host read after two edges
// - without a read further edges leave the interrupt unchanged
// - undervoltage or output configuration also release the interrupt
// - converter and standby are and of host and pin commands
// - trigger edge select high picks rising, low picks falling edge
// - output high releases the pin; output low pulls it low

module gpx_top #(
    parameter int NPIN = 3
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             ce,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic [NPIN-1:0]  pin_in,
    output logic      [NPIN-1:0]  pin_out,
    output logic      [NPIN-1:0]  pin_oe,
    input  wire logic             uvlo,
    output logic                  int_b,
    output logic                  buck_converter_one_on,
    output logic                  buck_converter_two_on,
    output logic                  buck_standby,
    output logic                  adc_start
);

    // -----------------------------------------------------------------
    // registers and wires
    // -----------------------------------------------------------------
    logic [7:0]                      pin12_q;
    logic [7:0]                      pin3_q;
    logic [7:0]                      adc_q;
    logic [7:0]                      cmd_q;
    logic [1:0]                      mask_q;
    logic [gpx_pkg::SYNC_W-1:0]      sync2_q;
    logic                            pin3_prev_q;
    logic [31:0]                     prdata_q;
    logic                            pready_q;
    logic                            pslverr_q;
    logic [NPIN-1:0]                 pin_oe_q;
    logic [NPIN-1:0]                 pin_out_q;
    logic                            int_b_q;
    logic                            buck1_q;
    logic                            buck2_q;
    logic                            sby_q;
    logic                            adc_start_q;
    logic [1:0]                      stage;
    logic [1:0]                      latch;
    logic [NPIN-1:0]                 pin_s;
    logic                            uvlo_s;
    logic                            setup;
    logic                            access_ok;
    logic                            wr_en;
    logic                            rd_en;
    logic                            hit_pin12;
    logic                            hit_pin3;
    logic                            hit_adc;
    logic                            hit_cmd;
    logic                            hit_status;
    logic                            hit_mask;
    logic                            mapped;
    logic                            rd_clr;
    logic [7:0]                      rd_mux;
    logic [7:0]                      status_val;
    logic [1:0]                      dir_out;
    logic [1:0]                      int_en;
    logic [1:0]                      arm;
    logic [1:0]                      kill;
    logic [1:0]                      lvl;
    logic [NPIN-1:0]                 dir_all;
    logic [NPIN-1:0]                 out_all;
    logic                            pin1_buck_mode;
    logic                            pin1_sby_mode;
    logic                            pin2_buck_mode;
    logic                            pin1_active;
    logic                            pin2_active;
    logic                            buck1_d;
    logic                            buck2_d;
    logic                            sby_d;
    logic                            trig_mode;
    logic                            trig_edge;
    logic                            int_b_d;

    // -----------------------------------------------------------------
    // pin and undervoltage synchronisers
    // -----------------------------------------------------------------
    // first stage feeds only the second; everything reads sync2_q
    genvar gi;
    generate
        for (gi = 0; gi < gpx_pkg::SYNC_W; gi++) begin : g_sync
            logic raw;
            logic s1_q;
            logic s2_q;
            // pick the source by generate so no pin index runs past NPIN
            if (gi == gpx_pkg::UVLO_BIT) begin : g_uv
                assign raw = uvlo;
            end else begin : g_pin
                assign raw = pin_in[gi];
            end
            // each lane owns its flops; one process per variable
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                end else if (ce) begin
                    s1_q <= raw;
                    s2_q <= s1_q;
                end
            end
            assign sync2_q[gi] = s2_q;
        end
    endgenerate

    assign pin_s  = sync2_q[NPIN-1:0];
    assign uvlo_s = sync2_q[gpx_pkg::UVLO_BIT];

    // -----------------------------------------------------------------
    // apb decode
    // -----------------------------------------------------------------
    // one wait-free access phase: pready rises on the first access cycle
    assign setup      = psel & ~penable;
    assign access_ok  = psel & penable & pready_q;
    assign wr_en      = access_ok & pwrite;
    assign rd_en      = access_ok & ~pwrite;
    assign hit_pin12  = paddr == gpx_pkg::ADDR_PIN12;
    assign hit_pin3   = paddr == gpx_pkg::ADDR_PIN3;
    assign hit_adc    = paddr == gpx_pkg::ADDR_ADC;
    assign hit_cmd    = paddr == gpx_pkg::ADDR_CMD;
    assign hit_status = paddr == gpx_pkg::ADDR_STATUS;
    assign hit_mask   = paddr == gpx_pkg::ADDR_MASK;
    assign mapped     = hit_pin12 | hit_pin3 | hit_adc | hit_cmd
                      | hit_status | hit_mask;
    assign rd_clr     = rd_en & hit_status;

    // status shows the block's own interrupt and pin state
    assign status_val = {int_b_q, pin_s, stage, latch};

    assign rd_mux = hit_pin12  ? pin12_q :
                    hit_pin3   ? pin3_q :
                    hit_adc    ? adc_q :
                    hit_cmd    ? cmd_q :
                    hit_status ? status_val :
                    hit_mask   ? {6'h00, mask_q} : 8'h00;

    // bus answer registers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else if (ce) begin
            pready_q  <= setup;
            pslverr_q <= setup & ~mapped;
            prdata_q  <= {24'h00_0000, rd_mux};
        end
    end

    // -----------------------------------------------------------------
    // software registers
    // -----------------------------------------------------------------
    // reset leaves every pin an input with no function chosen
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin12_q <= gpx_pkg::RST_CFG;
            pin3_q  <= gpx_pkg::RST_CFG;
            adc_q   <= gpx_pkg::RST_CFG;
            cmd_q   <= gpx_pkg::RST_CMD;
            mask_q  <= gpx_pkg::RST_MASK;
        end else if (ce && wr_en) begin
            if (hit_pin12) pin12_q <= pwdata[7:0];
            if (hit_pin3)  pin3_q  <= pwdata[7:0];
            if (hit_adc)   adc_q   <= pwdata[7:0];
            if (hit_cmd)   cmd_q   <= pwdata[7:0];
            if (hit_mask)  mask_q  <= pwdata[1:0];
        end
    end

    // -----------------------------------------------------------------
    // open-drain pin drive
    // -----------------------------------------------------------------
    assign dir_all = {pin3_q[gpx_pkg::PIN3_DIR],
                      pin12_q[gpx_pkg::PIN12_DIR2],
                      pin12_q[gpx_pkg::PIN12_DIR1]};
    assign out_all = {pin3_q[gpx_pkg::PIN3_OUT],
                      pin12_q[gpx_pkg::PIN12_OUT2],
                      pin12_q[gpx_pkg::PIN12_OUT1]};

    // high releases the pin, low enables the pull-down
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_oe_q  <= '0;
            pin_out_q <= '0;
        end else if (ce) begin
            pin_oe_q  <= dir_all & ~out_all;
            pin_out_q <= '0;
        end
    end

    // -----------------------------------------------------------------
    // edge interrupt cells for pins one and two
    // -----------------------------------------------------------------
    assign dir_out = dir_all[1:0];
    assign int_en  = {pin3_q[gpx_pkg::PIN3_INT2_EN],
                      pin3_q[gpx_pkg::PIN3_INT1_EN]};
    assign lvl     = {pin12_q[gpx_pkg::PIN12_LVL2],
                      pin12_q[gpx_pkg::PIN12_LVL1]};
    assign arm     = int_en & ~dir_out;
    assign kill    = ~arm | {2{uvlo_s}};

    generate
        for (gi = 0; gi < 2; gi++) begin : g_irq
            gpx_edge_cell u_cell (
                .clk      (clk),
                .rst_b    (rst_b),
                .ce       (ce),
                .pin_s    (pin_s[gi]),
                .arm      (arm[gi]),
                .fall_sel (lvl[gi]),
                .rd_clr   (rd_clr),
                .kill     (kill[gi]),
                .stage_q  (stage[gi]),
                .latch_q  (latch[gi])
            );
        end
    endgenerate

    // unmasked latches pull the shared line low
    assign int_b_d = ~|(latch & ~mask_q);

    // -----------------------------------------------------------------
    // converter and standby control
    // -----------------------------------------------------------------
    // software must keep pin functions exclusive; no arbitration here
    assign pin1_buck_mode = ~dir_out[0]
                          & pin12_q[gpx_pkg::PIN12_BUCK1_SEL];
    assign pin1_sby_mode  = ~dir_out[0]
                          & pin12_q[gpx_pkg::PIN12_SBY_SEL];
    assign pin2_buck_mode = ~dir_out[1]
                          & pin3_q[gpx_pkg::PIN3_BUCK2_SEL];
    assign pin1_active    = pin_s[0] == lvl[0];
    assign pin2_active    = pin_s[1] == lvl[1];

    // either side saying off or normal wins
    assign buck1_d = cmd_q[gpx_pkg::CMD_BUCK1_ON]
                   & (~pin1_buck_mode | pin1_active);
    assign buck2_d = cmd_q[gpx_pkg::CMD_BUCK2_ON]
                   & (~pin2_buck_mode | pin2_active);
    assign sby_d   = cmd_q[gpx_pkg::CMD_STANDBY]
                   & (~pin1_sby_mode | pin1_active);

    // -----------------------------------------------------------------
    // adc start trigger on pin three
    // -----------------------------------------------------------------
    assign trig_mode = ~dir_all[2] & adc_q[gpx_pkg::ADC_TRIG_EN];
    assign trig_edge = adc_q[gpx_pkg::ADC_TRIGGER_EDGE_SELECT]
                     ? (~pin3_prev_q & pin_s[2])
                     : (pin3_prev_q & ~pin_s[2]);

    // output flops; adc_start is a one-cycle pulse
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin3_prev_q <= 1'b0;
            int_b_q     <= 1'b1;
            buck1_q     <= 1'b0;
            buck2_q     <= 1'b0;
            sby_q       <= 1'b0;
            adc_start_q <= 1'b0;
        end else if (ce) begin
            pin3_prev_q <= pin_s[2];
            int_b_q     <= int_b_d;
            buck1_q     <= buck1_d;
            buck2_q     <= buck2_d;
            sby_q       <= sby_d;
            adc_start_q <= trig_mode & trig_edge;
        end
    end

    assign prdata                = prdata_q;
    assign pready                = pready_q;
    assign pslverr               = pslverr_q;
    assign pin_oe                = pin_oe_q;
    assign pin_out               = pin_out_q;
    assign int_b                 = int_b_q;
    assign buck_converter_one_on = buck1_q;
    assign buck_converter_two_on = buck2_q;
    assign buck_standby          = sby_q;
    assign adc_start             = adc_start_q;

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    sequence s_drive_low;
        ce && wr_en && hit_pin12 && pwdata[gpx_pkg::PIN12_DIR1]
           && !pwdata[gpx_pkg::PIN12_OUT1];
    endsequence

    property p_drive_low;
        @(posedge clk) disable iff (!rst_b)
        s_drive_low ##1 ce |=> pin_oe_q[0];
    endproperty
    a_drive_low: assert property (p_drive_low)
        else $error("pin one not pulled low after output-low write");

    property p_mask;
        @(posedge clk) disable iff (!rst_b)
        ce |=> int_b_q == !$past(|(latch & ~mask_q));
    endproperty
    a_mask: assert property (p_mask)
        else $error("interrupt line disagrees with masked latches");

    property p_host_off;
        @(posedge clk) disable iff (!rst_b)
        ce && !cmd_q[gpx_pkg::CMD_BUCK1_ON] |=> !buck1_q;
    endproperty
    a_host_off: assert property (p_host_off)
        else $error("converter one on despite host off");

    property p_pin2_off;
        @(posedge clk) disable iff (!rst_b)
        ce && pin2_buck_mode && pin_s[1] != lvl[1] |=> !buck2_q;
    endproperty
    a_pin2_off: assert property (p_pin2_off)
        else $error("converter two on with pin two inactive");

    property p_adc_fall;
        @(posedge clk) disable iff (!rst_b)
        ce && trig_mode && !adc_q[gpx_pkg::ADC_TRIGGER_EDGE_SELECT]
           && pin3_prev_q && !pin_s[2] |=> adc_start_q;
    endproperty
    a_adc_fall: assert property (p_adc_fall)
        else $error("falling edge on pin three did not start adc");

    sequence s_uvlo_held;
        (ce && uvlo_s) ##1 (ce && uvlo_s);
    endsequence

    property p_uvlo_release;
        @(posedge clk) disable iff (!rst_b)
        s_uvlo_held |=> int_b_q;
    endproperty
    a_uvlo_release: assert property (p_uvlo_release)
        else $error("interrupt line held low during undervoltage");

endmodule // gpx_top

/* design/gpx_pkg.sv */
package gpx_pkg;

    // -----------------------------------------------------------------
    // register byte addresses
    // -----------------------------------------------------------------
    localparam logic [11:0] ADDR_PIN12  = 12'h000;
    localparam logic [11:0] ADDR_PIN3   = 12'h004;
    localparam logic [11:0] ADDR_ADC    = 12'h008;
    localparam logic [11:0] ADDR_CMD    = 12'h00C;
    localparam logic [11:0] ADDR_STATUS = 12'h010;
    localparam logic [11:0] ADDR_MASK   = 12'h014;

    // -----------------------------------------------------------------
    // pin one / pin two configuration fields
    // -----------------------------------------------------------------
    localparam int PIN12_BUCK1_SEL = 0;
    localparam int PIN12_SBY_SEL   = 1;
    localparam int PIN12_LVL1      = 2;
    localparam int PIN12_LVL2      = 3;
    localparam int PIN12_OUT1      = 4;
    localparam int PIN12_OUT2      = 5;
    localparam int PIN12_DIR1      = 6;
    localparam int PIN12_DIR2      = 7;

    // -----------------------------------------------------------------
    // pin three configuration and function selects
    // -----------------------------------------------------------------
    localparam int PIN3_DIR       = 0;
    localparam int PIN3_OUT       = 1;
    localparam int PIN3_INT1_EN   = 2;
    localparam int PIN3_INT2_EN   = 3;
    localparam int PIN3_BUCK2_SEL = 4;

    // -----------------------------------------------------------------
    // adc trigger and host command fields
    // -----------------------------------------------------------------
    localparam int ADC_TRIG_EN            = 0;
    localparam int ADC_TRIGGER_EDGE_SELECT = 1;
    localparam int CMD_BUCK1_ON           = 0;
    localparam int CMD_BUCK2_ON           = 1;
    localparam int CMD_STANDBY            = 2;

    // -----------------------------------------------------------------
    // reset values and widths
    // -----------------------------------------------------------------
    localparam int          REG_W     = 8;
    localparam logic [7:0]  RST_CFG   = 8'h00;
    localparam logic [7:0]  RST_CMD   = 8'h00;
    localparam logic [1:0]  RST_MASK  = 2'h0;
    localparam int          SYNC_W    = 4;
    localparam int          UVLO_BIT  = 3;

endpackage

/* design/gpx_edge_cell.sv */
`timescale 1ns/1ps

module gpx_edge_cell (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic ce,
    input  wire logic pin_s,
    input  wire logic arm,
    input  wire logic fall_sel,
    input  wire logic rd_clr,
    input  wire logic kill,
    output logic      stage_q,
    output logic      latch_q
);

    logic prev_q;
    logic rise;
    logic fall;
    logic sel_edge;
    logic opp_edge;
    logic stage_d;
    logic latch_d;

    // -----------------------------------------------------------------
    // edge detect on the already synchronised pin
    // -----------------------------------------------------------------
    assign rise     = ~prev_q & pin_s;
    assign fall     = prev_q & ~pin_s;
    assign sel_edge = arm & (fall_sel ? fall : rise);
    assign opp_edge = arm & (fall_sel ? rise : fall);

    // first stage: set by the chosen edge, cleared by the opposite one
    assign stage_d = kill     ? 1'b0 :
                     sel_edge ? 1'b1 :
                     opp_edge ? 1'b0 : stage_q;

    // output latch: set wins over a read in the same cycle
    assign latch_d = kill              ? 1'b0 :
                     sel_edge          ? 1'b1 :
                     rd_clr & ~stage_q ? 1'b0 : latch_q;

    // state update, frozen while ce is low
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prev_q  <= 1'b0;
            stage_q <= 1'b0;
            latch_q <= 1'b0;
        end else if (ce) begin
            prev_q  <= pin_s;
            stage_q <= stage_d;
            latch_q <= latch_d;
        end
    end

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    sequence s_edge_set;
        ce && !kill && sel_edge;
    endsequence

    property p_first_edge;
        @(posedge clk) disable iff (!rst_b)
        s_edge_set |=> stage_q && latch_q;
    endproperty
    a_first_edge: assert property (p_first_edge)
        else $error("selected edge did not set stage and latch");

    property p_read_blocked;
        @(posedge clk) disable iff (!rst_b)
        ce && !kill && stage_q && latch_q |=> latch_q;
    endproperty
    a_read_blocked: assert property (p_read_blocked)
        else $error("latch cleared while first stage still set");

    sequence s_armed_read;
        ce && !kill && latch_q && !stage_q && rd_clr && !sel_edge;
    endsequence

    property p_read_clears;
        @(posedge clk) disable iff (!rst_b)
        s_armed_read |=> !latch_q;
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("read after two edges did not clear latch");

    property p_no_read_hold;
        @(posedge clk) disable iff (!rst_b)
        ce && !kill && latch_q && !rd_clr |=> latch_q;
    endproperty
    a_no_read_hold: assert property (p_no_read_hold)
        else $error("latch changed without a host read");

endmodule // gpx_edge_cell

/* sim/gpx_pin_model.sv */
`timescale 1ns/1ps

// far side of the pins: pull-up plus an outside switch to ground
module gpx_pin_model (
    input  wire logic [2:0] pin_oe,
    input  wire logic [2:0] ext_low,
    output logic      [2:0] pin_lvl
);
    // open drain: the pull-up wins unless either party pulls low
    assign pin_lvl = ~(pin_oe | ext_low);
endmodule // gpx_pin_model

/* sim/gpx_top_tb_top.sv */
`timescale 1ns/1ps

module gpx_top_tb_top;
    logic        clk, rst_b, psel, penable, pwrite, uvlo;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [31:0] npulse = 32'h0000_0000;
    logic        pready, pslverr, int_b, b1, b2, sby, adc_start, err;
    logic [2:0]  pin_out, pin_oe, ext, lvl;
    int          fails, num_checks;

    gpx_pin_model i_pins (.pin_oe(pin_oe), .ext_low(ext), .pin_lvl(lvl));
    gpx_top i_dut (.clk(clk), .rst_b(rst_b), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pin_in(lvl), .pin_out(pin_out),
        .pin_oe(pin_oe), .uvlo(uvlo), .int_b(int_b),
        .buck_converter_one_on(b1), .buck_converter_two_on(b2),
        .buck_standby(sby), .adc_start(adc_start));

    // ---------------------------------------------------------------
    // clock, pulse counter, shared tasks
    // ---------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // a one-cycle pulse is easy to miss by sampling, so count it
    always @(posedge clk) begin
        if (adc_start === 1'b1) npulse <= npulse + 32'h0000_0001;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // apb master: hold the request until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [7:0] d);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task automatic pin(input int n, input logic lo);
        ext[n] <= lo;
        repeat (6) @(posedge clk);
    endtask
    task automatic wrap_up;
        $display("checks=%0d fails=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_reset;
        chk({int_b, pin_oe, b1, b2, sby}, 32'h0000_0040);
        apb(1'b0, 12'h018, 8'h00);
        chk(rd, 32'h0000_0000);
        chk(err, 32'h0000_0001);
        chk(pin_out, 32'h0000_0000);
    endtask
    task automatic t_out;
        apb(1'b1, gpx_pkg::ADDR_PIN12, 8'h40);
        chk({pin_oe, lvl[0]}, 4'h2);
        chk(pin_out, 32'h0000_0000);
        apb(1'b1, gpx_pkg::ADDR_PIN12, 8'h50);
        chk({pin_oe, lvl[0]}, 4'h1);
    endtask
    // rising edge armed; second edge plus read releases the line
    task automatic t_irq;
        pin(0, 1'b1);
        apb(1'b1, gpx_pkg::ADDR_PIN12, 8'h00);
        apb(1'b1, gpx_pkg::ADDR_PIN3, 8'h04);
        pin(0, 1'b0);
        chk(int_b, 1'b0);
        apb(1'b0, gpx_pkg::ADDR_STATUS, 8'h00);
        chk(rd, 32'h0000_0075);
        chk(int_b, 1'b0);
        pin(0, 1'b1);
        chk(int_b, 1'b0);
        apb(1'b0, gpx_pkg::ADDR_STATUS, 8'h00);
        chk(rd, 32'h0000_0061);
        chk(int_b, 1'b1);
        apb(1'b1, gpx_pkg::ADDR_MASK, 8'h01);
        pin(0, 1'b0);
        chk(int_b, 1'b1);
        apb(1'b1, gpx_pkg::ADDR_MASK, 8'h00);
        chk(int_b, 1'b0);
        apb(1'b1, gpx_pkg::ADDR_PIN12, 8'h40);
        // disarm clears the latch one edge later, the line one after
        @(posedge clk);
        chk(int_b, 1'b1);
        apb(1'b1, gpx_pkg::ADDR_PIN3, 8'h00);
    endtask
    // falling edge on pin two, then undervoltage releases the line
    task automatic t_uvlo;
        apb(1'b1, gpx_pkg::ADDR_PIN12, 8'h08);
        apb(1'b1, gpx_pkg::ADDR_PIN3, 8'h08);
        pin(1, 1'b1);
        chk(int_b, 1'b0);
        uvlo <= 1'b1;
        repeat (6) @(posedge clk);
        chk(int_b, 1'b1);
        uvlo <= 1'b0;
        apb(1'b1, gpx_pkg::ADDR_PIN3, 8'h00);
        pin(1, 1'b0);
    endtask
    task automatic t_buck;
        apb(1'b1, gpx_pkg::ADDR_CMD, 8'h07);
        apb(1'b1, gpx_pkg::ADDR_PIN3, 8'h10);
        apb(1'b1, gpx_pkg::ADDR_PIN12, 8'h08);
        pin(1, 1'b0);
        chk({b1, b2, sby}, 3'h7);
        pin(1, 1'b1);
        chk({b1, b2, sby}, 3'h5);
        pin(1, 1'b0);
        apb(1'b1, gpx_pkg::ADDR_PIN12, 8'h09);
        chk({b1, b2, sby}, 3'h3);
        apb(1'b1, gpx_pkg::ADDR_PIN12, 8'h0A);
        chk({b1, b2, sby}, 3'h6);
        apb(1'b1, gpx_pkg::ADDR_CMD, 8'h00);
        chk({b1, b2, sby}, 3'h0);
    endtask
    task automatic t_adc;
        apb(1'b1, gpx_pkg::ADDR_ADC, 8'h03);
        pin(2, 1'b1);
        chk(npulse, 32'h0000_0000);
        pin(2, 1'b0);
        chk(npulse, 32'h0000_0001);
        apb(1'b1, gpx_pkg::ADDR_ADC, 8'h01);
        pin(2, 1'b1);
        chk(npulse, 32'h0000_0002);
    endtask

    // ---------------------------------------------------------------
    // main sequence and watchdog
    // ---------------------------------------------------------------
    initial begin
        rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0000_0000; uvlo = 1'b0;
        ext = 3'h0; fails = 0; num_checks = 0;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        t_reset;
        t_out;
        t_irq;
        t_uvlo;
        t_buck;
        t_adc;
        wrap_up;
    end
    // all scenarios need well under 1000 cycles
    initial begin
        #50000;
        fails++;
        wrap_up;
    end
endmodule // gpx_top_tb_top
